// *** core/iaf_consts.svh ***
// constants of the pointer-indirect access and alu flag block
// assumes inclusion by bare name from the block's sources only
// Functional notes
// RQ1: a virtual port operand really accesses the location its pointer holds
// RQ2: each pointer holds a 12-bit address built from a high and low byte
// RQ3: three independent pointers, each with own ports, spanning 4096 bytes
// RQ4: indirect read through a pointer aimed at a port gives zero, sets zero
// RQ5: indirect write through a pointer aimed at a port does nothing at all; the write is dropped but the port's pointer update still applies
// RQ6: five ports per pointer; the port used picks the pointer update
// RQ7: plain port uses the pointer as is and leaves it unchanged
// RQ8: post-decrement port uses the pointer, then subtracts one
// RQ9: post-increment port uses the pointer, then adds one
// RQ10: pre-increment port adds one first, then accesses the new address
// RQ11: indexed port adds signed working value; pointer and working kept
// RQ12: pointer steps never touch any flag, even on reaching zero
// RQ13: pointer steps act on all 12 bits, carrying between bytes
// RQ14: indirect write to a pointer's own byte beats its auto update
// RQ15: alu result aimed at the flag register: alu flags win over data
// RQ16: flag register bits 7 to 5 are absent and read zero
// RQ17: negative flag copies result bit 7
// RQ18: overflow flag marks a wrong sign change in signed arithmetic
// RQ19: zero flag set when the result is zero, cleared otherwise
// RQ20: half carry from bit 3 on add and subtract, bit 4 or 3 on rotate
// RQ21: carry from bit 7 on add and subtract, high or low bit on rotate
// RQ22: subtract adds the two's complement, carries act as inverted borrow
// RQ23: working value sign-extended to 12 bits, sum wraps in 12 bits
`ifndef IAF_CONSTS_SVH
`define IAF_CONSTS_SVH

// ==========================================================
// address map, bus word index equals data address
`define IAF_PTR0_BLK    9'h1fb
`define IAF_PTR1_BLK    9'h1fc
`define IAF_PTR2_BLK    9'h1fd
`define IAF_OFF_PLAIN   3'h0
`define IAF_OFF_POSTDEC 3'h1
`define IAF_OFF_POSTINC 3'h2
`define IAF_OFF_PREINC  3'h3
`define IAF_OFF_INDEXED 3'h4
`define IAF_OFF_LOW     3'h5
`define IAF_OFF_HIGH    3'h6
`define IAF_FLAG_ADDR   12'hff0
`define IAF_WORK_ADDR   12'hff1
`define IAF_OPND_ADDR   12'hff2
`define IAF_CMD_ADDR    12'hff3

// ==========================================================
// field positions
`define IAF_FLG_N       4
`define IAF_FLG_OVF     3
`define IAF_FLG_Z       2
`define IAF_FLG_HC      1
`define IAF_FLG_C       0
`define IAF_CMD_DEST    3

// ==========================================================
// reset values
`define IAF_PTR_RST     12'h000
`define IAF_FLAG_RST    5'h00
`define IAF_BYTE_RST    8'h00

`endif

// *** core/iaf_pkg.sv ***
// types of the pointer-indirect access and alu flag block
// assumes nothing beyond the constants header
package iaf_pkg;

  // ==========================================================
  // alu operations
  typedef enum logic [2:0]
  {
    IAF_OP_ADD = 3'h0,
    IAF_OP_SUB = 3'h1,
    IAF_OP_AND = 3'h2,
    IAF_OP_IOR = 3'h3,
    IAF_OP_XOR = 3'h4,
    IAF_OP_RLC = 3'h5,
    IAF_OP_RRC = 3'h6,
    IAF_OP_MOV = 3'h7
  } iaf_op_e;

  typedef logic [11:0] iaf_addr_t;
  typedef logic [1:0]  iaf_sel_t;

endpackage

// *** core/iaf_top.sv ***
// pointer-indirect data access, working register and alu flag register
// assumes one 100 mhz clock, synchronous active-high reset and an
// avalon-mm master that holds each request until waitrequest is low
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "iaf_consts.svh"

module iaf_top
  import iaf_pkg::*;
#(
  parameter int RAM_DEPTH = 4096
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);

  // ==========================================================
  // elaboration check
  if (RAM_DEPTH < 256 || RAM_DEPTH > 4096)
  begin : g_chk
    $error("RAM_DEPTH must lie in 256..4096");
  end

  // ==========================================================
  // decode functions
  function automatic iaf_sel_t blk_of(input iaf_addr_t a);
    iaf_sel_t r;
    r = 2'h3;
    if (a[11:3] == `IAF_PTR0_BLK) r = 2'h0;
    if (a[11:3] == `IAF_PTR1_BLK) r = 2'h1;
    if (a[11:3] == `IAF_PTR2_BLK) r = 2'h2;
    return r;
  endfunction

  function automatic logic is_port(input iaf_addr_t a);
    return (blk_of(a) != 2'h3) && (a[2:0] <= `IAF_OFF_INDEXED);
  endfunction

  // ==========================================================
  // state
  iaf_addr_t  ptr [3];
  iaf_addr_t  next_ptr [3];
  logic [4:0] flags;
  logic [4:0] next_flags;
  logic [7:0] work;
  logic [7:0] next_work;
  logic [7:0] opnd;
  logic [7:0] rdata;
  logic [7:0] rd_mux;
  logic       ack;
  logic [7:0] ram [RAM_DEPTH];

  // ==========================================================
  // bus handshake: one wait state on every access
  logic req;
  logic go;
  assign req = avs_read | avs_write;
  assign go  = req & ack;
  assign avs_waitrequest = req & ~ack;
  assign avs_readdata    = {24'h000000, rdata};

  // ==========================================================
  // address generation
  iaf_sel_t   a_blk;
  logic [2:0] a_off;
  logic       direct_port;
  iaf_sel_t   sel;
  iaf_addr_t  cur_ptr;
  iaf_addr_t  wext;
  iaf_addr_t  ptr_inc;
  iaf_addr_t  ptr_dec;
  iaf_addr_t  ptr_idx;
  iaf_addr_t  target;
  iaf_addr_t  eff;
  iaf_addr_t  upd_ptr;
  logic       eff_virtual;

  assign a_blk       = blk_of(avs_address);
  assign a_off       = avs_address[2:0];
  assign direct_port = is_port(avs_address); // RQ6
  assign sel         = direct_port ? a_blk : 2'h0;
  assign cur_ptr     = ptr[sel];
  assign wext        = {{4{work[7]}}, work}; // RQ23
  assign ptr_inc     = cur_ptr + 12'h001; // RQ13
  assign ptr_dec     = cur_ptr - 12'h001; // RQ13
  assign ptr_idx     = cur_ptr + wext; // RQ11
  assign target      = (a_off == `IAF_OFF_PREINC)  ? ptr_inc : // RQ10
                       (a_off == `IAF_OFF_INDEXED) ? ptr_idx : cur_ptr;
  assign eff         = direct_port ? target : avs_address; // RQ1
  assign eff_virtual = direct_port & is_port(target);
  assign upd_ptr     = (a_off == `IAF_OFF_POSTDEC) ? ptr_dec : // RQ8
                       (a_off == `IAF_OFF_POSTINC ||
                        a_off == `IAF_OFF_PREINC)  ? ptr_inc : // RQ9
                       cur_ptr; // RQ7

  // ==========================================================
  // write decode
  logic       do_wr;
  logic [7:0] wbyte;
  iaf_sel_t   e_blk;
  logic [2:0] e_off;
  logic       sfr_hit;
  logic       ram_hit;
  logic       alu_go;
  logic       flag_wr;
  logic       work_wr;
  logic       opnd_wr;

  // a write through a port aimed at a port is dropped
  assign do_wr   = go & avs_write & avs_byteenable[0] & ~eff_virtual; // RQ5
  assign wbyte   = avs_writedata[7:0];
  assign e_blk   = blk_of(eff);
  assign e_off   = eff[2:0];
  assign sfr_hit = (e_blk != 2'h3) ||
                   (eff[11:2] == 10'(`IAF_FLAG_ADDR >> 2));
  assign ram_hit = !sfr_hit && (32'(eff) < RAM_DEPTH);
  assign alu_go  = do_wr && (eff == `IAF_CMD_ADDR);
  assign flag_wr = do_wr && (eff == `IAF_FLAG_ADDR);
  assign work_wr = do_wr && (eff == `IAF_WORK_ADDR);
  assign opnd_wr = do_wr && (eff == `IAF_OPND_ADDR);

  // ==========================================================
  // read path
  always_comb
  begin
    rd_mux = `IAF_BYTE_RST;
    if (eff_virtual)
      rd_mux = 8'h00; // RQ4
    else if (e_blk != 2'h3)
    begin
      if (e_off == `IAF_OFF_LOW)
        rd_mux = ptr[e_blk][7:0];
      else if (e_off == `IAF_OFF_HIGH)
        rd_mux = {4'h0, ptr[e_blk][11:8]}; // RQ2
    end
    else if (eff == `IAF_FLAG_ADDR)
      rd_mux = {3'h0, flags}; // RQ16
    else if (eff == `IAF_WORK_ADDR)
      rd_mux = work;
    else if (eff == `IAF_OPND_ADDR)
      rd_mux = opnd;
    else if (ram_hit)
      rd_mux = ram[eff];
  end

  // ==========================================================
  // pointer update
  always_comb
  begin
    for (int i = 0; i < 3; i++) // RQ3
    begin
      next_ptr[i] = ptr[i];
      // an explicit write to the pointer's own byte wins
      if (do_wr && e_blk == 2'(i) && e_off == `IAF_OFF_LOW)
        next_ptr[i] = {ptr[i][11:8], wbyte}; // RQ14
      else if (do_wr && e_blk == 2'(i) && e_off == `IAF_OFF_HIGH)
        next_ptr[i] = {wbyte[3:0], ptr[i][7:0]}; // RQ14
      else if (go && direct_port && a_blk == 2'(i))
        next_ptr[i] = upd_ptr; // RQ6
    end
  end

  // ==========================================================
  // alu
  iaf_op_e    op;
  logic       dest_f;
  logic       is_sub;
  logic [7:0] bb;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic [7:0] alu_res;
  logic [4:0] alu_flg;
  logic [4:0] alu_msk;

  assign op     = iaf_op_e'(wbyte[2:0]);
  assign dest_f = wbyte[`IAF_CMD_DEST];
  assign is_sub = (op == IAF_OP_SUB);
  // subtract is opnd plus two's complement of the working value
  assign bb     = is_sub ? ~work : work; // RQ22
  assign sum9   = 9'(opnd) + 9'(bb) + 9'(is_sub);
  assign half5  = 5'(opnd[3:0]) + 5'(bb[3:0]) + 5'(is_sub);

  always_comb
  begin
    alu_res = opnd;
    alu_flg = flags;
    alu_msk = 5'h00;
    alu_msk[`IAF_FLG_N] = 1'b1;
    alu_msk[`IAF_FLG_Z] = 1'b1;
    case (op)
      IAF_OP_ADD, IAF_OP_SUB:
      begin
        alu_res = sum9[7:0];
        alu_flg[`IAF_FLG_C]  = sum9[8]; // RQ21
        alu_flg[`IAF_FLG_HC] = half5[4]; // RQ20
        alu_flg[`IAF_FLG_OVF] = (opnd[7] == bb[7]) &&
                                (sum9[7] != opnd[7]); // RQ18
        alu_msk = 5'h1f;
      end
      IAF_OP_AND: alu_res = opnd & work;
      IAF_OP_IOR: alu_res = opnd | work;
      IAF_OP_XOR: alu_res = opnd ^ work;
      IAF_OP_RLC:
      begin
        alu_res = {opnd[6:0], flags[`IAF_FLG_C]};
        alu_flg[`IAF_FLG_C]  = opnd[7]; // RQ21
        alu_flg[`IAF_FLG_HC] = opnd[3]; // RQ20
        alu_msk[`IAF_FLG_C]  = 1'b1;
        alu_msk[`IAF_FLG_HC] = 1'b1;
      end
      IAF_OP_RRC:
      begin
        alu_res = {flags[`IAF_FLG_C], opnd[7:1]};
        alu_flg[`IAF_FLG_C]  = opnd[0]; // RQ21
        alu_flg[`IAF_FLG_HC] = opnd[4]; // RQ20
        alu_msk[`IAF_FLG_C]  = 1'b1;
        alu_msk[`IAF_FLG_HC] = 1'b1;
      end
      IAF_OP_MOV: alu_res = opnd;
      default:    alu_res = opnd;
    endcase
    alu_flg[`IAF_FLG_N] = alu_res[7]; // RQ17
    alu_flg[`IAF_FLG_Z] = (alu_res == 8'h00); // RQ19
  end

  // ==========================================================
  // flag and working register next values
  always_comb
  begin
    // pointer steps feed nothing here, so flags never see them
    next_flags = flags; // RQ12
    if (alu_go)
      next_flags = (flags & ~alu_msk) | (alu_flg & alu_msk); // RQ15
    else if (flag_wr)
      next_flags = wbyte[4:0];
    if (go && avs_read && eff_virtual)
      next_flags[`IAF_FLG_Z] = 1'b1; // RQ4
  end

  always_comb
  begin
    next_work = work;
    // flag destination: result bits are discarded, flags take alu
    if (alu_go && !dest_f)
      next_work = alu_res;
    else if (work_wr)
      next_work = wbyte;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack   <= 1'b0;
      rdata <= `IAF_BYTE_RST;
      flags <= `IAF_FLAG_RST;
      work  <= `IAF_BYTE_RST;
      opnd  <= `IAF_BYTE_RST;
      ptr   <= '{`IAF_PTR_RST, `IAF_PTR_RST, `IAF_PTR_RST};
    end
    else
    begin
      ack   <= req & ~ack;
      if (req && !ack)
        rdata <= rd_mux;
      flags <= next_flags;
      work  <= next_work;
      if (opnd_wr)
        opnd <= wbyte;
      ptr   <= next_ptr;
    end
  end

  // data memory has no reset
  always_ff @(posedge clk)
  begin
    if (do_wr && ram_hit)
      ram[eff] <= wbyte; // RQ1
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic hit0;
  logic go_p0;
  assign hit0  = do_wr && (e_blk == 2'h0) &&
                 (e_off == `IAF_OFF_LOW || e_off == `IAF_OFF_HIGH);
  assign go_p0 = go && direct_port && (a_blk == 2'h0) && !hit0;

  sequence s_req0(logic [2:0] m);
    go_p0 && (a_off == m);
  endsequence

  sequence s_vread;
    go && avs_read && eff_virtual;
  endsequence

  AST_PLAIN_HOLD: assert property ( // RQ7
    s_req0(`IAF_OFF_PLAIN) |=> $stable(ptr[0]))
    else $error("plain port changed the pointer");

  AST_POSTDEC: assert property ( // RQ8
    s_req0(`IAF_OFF_POSTDEC) |->
      (eff == ptr[0]) ##1 (ptr[0] == $past(ptr[0]) - 12'h001))
    else $error("post-decrement wrong");

  AST_POSTINC: assert property ( // RQ9
    s_req0(`IAF_OFF_POSTINC) |->
      (eff == ptr[0]) ##1 (ptr[0] == $past(ptr[0]) + 12'h001))
    else $error("post-increment wrong");

  AST_PREINC: assert property ( // RQ10
    s_req0(`IAF_OFF_PREINC) |->
      (eff == ptr[0] + 12'h001) ##1 (ptr[0] == $past(eff)))
    else $error("pre-increment wrong");

  AST_INDEXED: assert property ( // RQ11
    s_req0(`IAF_OFF_INDEXED) and avs_read |->
      (eff == ptr[0] + {{4{work[7]}}, work}) ##1
      ($stable(ptr[0]) && $stable(work)))
    else $error("indexed access wrong");

  AST_VREAD: assert property ( // RQ4
    s_vread |-> (avs_readdata == 32'h0) ##1 flags[`IAF_FLG_Z])
    else $error("virtual read not zero");

  AST_VWRITE: assert property ( // RQ5
    go && avs_write && eff_virtual |=> $stable(flags) && $stable(work))
    else $error("virtual write had an effect");

  AST_OWN_WR: assert property ( // RQ14
    go && direct_port && (a_blk == 2'h0) && do_wr &&
    (eff == {`IAF_PTR0_BLK, `IAF_OFF_LOW}) |=>
      (ptr[0][7:0] == $past(avs_writedata[7:0])))
    else $error("pointer write lost to auto update");

  AST_FLAG_RSV: assert property ( // RQ16
    go && avs_read && (eff == `IAF_FLAG_ADDR) |->
      (avs_readdata[31:5] == 27'h0))
    else $error("flag upper bits not zero");

  AST_ALU_Z: assert property ( // RQ19
    alu_go |=> flags[`IAF_FLG_Z] == ($past(alu_res) == 8'h00))
    else $error("zero flag wrong");

  AST_DEST_FLAGS: assert property ( // RQ15
    alu_go && dest_f |=> $stable(work) &&
      (flags[`IAF_FLG_N] == $past(alu_res[7])))
    else $error("flag destination wrong");

  AST_SUB_C: assert property ( // RQ22
    alu_go && (op == IAF_OP_SUB) |=>
      flags[`IAF_FLG_C] == ($past(opnd) >= $past(work)))
    else $error("subtract carry wrong");

  AST_WAIT: assert property (
    req && !ack |=> !avs_waitrequest || !req)
    else $error("answer later than one wait state");

endmodule

`default_nettype wire

// *** verification/iaf_core_model.sv ***
// bus-master model of the instruction core facing the indirect block
// assumes the slave holds waitrequest high until it answers
`timescale 1ns/1ps
`default_nettype none

module iaf_core_model
(
  // clock
  input  wire logic        clk,
  // avalon-mm master
  output logic      [11:0] avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // ==========================================
  // idle drive
  initial
  begin
    avs_address    = 12'h000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h1;
  end

  // ==========================================
  // one transfer, held until waitrequest low
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= {24'h00_0000, d};
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // released lines flip so stale values are never trusted
    avs_writedata <= ~{24'h00_0000, d};
    avs_address   <= ~a;
  endtask

  // byte lane 0 enable, changed only between transfers
  task automatic lane0(input logic en);
    @(posedge clk);
    avs_byteenable <= {3'h0, en};
  endtask
endmodule

`default_nettype wire

// *** verification/tb_indirect_addr_and_alu_flags.sv ***
// self-checking bench for the indirect access and alu flag block
// assumes the core model as bus master and a 100 mhz clock
`timescale 1ns/1ps
`default_nettype none
`include "iaf_consts.svh"

`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("BAD %0t got %h exp %h", $time, g, e); \
    end \
  end

module tb_indirect_addr_and_alu_flags
  import iaf_pkg::*;
;
  logic        clk;
  logic        rst;
  logic [11:0] adr;
  logic        rd;
  logic        wrq;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_req;
  logic [7:0]  q;
  logic [7:0]  a;
  logic [7:0]  b;
  logic [7:0]  f8;
  logic [12:0] ex;
  int          fails;
  int          comparisons;
  int          cycles;
  int          seed;
  int          i;

  initial
  begin
    clk = 1'b0;
    forever
      #5 clk = ~clk;
  end

  iaf_top dut_u (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wrq), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wait_req));

  iaf_core_model core_u (.clk(clk), .avs_address(adr), .avs_read(rd),
    .avs_write(wrq), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wait_req));

  // ==========================================
  // helpers
  task automatic conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input iaf_addr_t ad, input logic [7:0] d);
    logic [7:0] unused;
    core_u.xfer(1'b1, ad, d, unused);
  endtask

  task automatic chk(input iaf_addr_t ad, input logic [7:0] e);
    core_u.xfer(1'b0, ad, 8'h00, q);
    `CHK(q, e)
  endtask

  function automatic iaf_addr_t pa(input int n,
                                   input logic [2:0] o);
    logic [8:0] blk;
    blk = `IAF_PTR0_BLK + 9'(n);
    return {blk, o};
  endfunction

  task automatic setp(input int n, input iaf_addr_t v);
    wr(pa(n, `IAF_OFF_LOW), v[7:0]);
    wr(pa(n, `IAF_OFF_HIGH), {4'h0, v[11:8]});
  endtask

  task automatic chkp(input int n, input iaf_addr_t v);
    chk(pa(n, `IAF_OFF_LOW), v[7:0]);
    chk(pa(n, `IAF_OFF_HIGH), {4'h0, v[11:8]});
  endtask

  // expected {result, flags}; flags n, overflow, z, half carry, c
  function automatic logic [12:0] alu(input logic [2:0] op,
    input logic [7:0] x, input logic [7:0] y, input logic [4:0] f);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] yy;
    logic [7:0] r;
    r = x;
    yy = op[0] ? ~y : y;
    case (op)
      3'h0, 3'h1:
      begin
        s = {1'b0, x} + {1'b0, yy} + {8'h00, op[0]};
        h = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, op[0]};
        r = s[7:0];
        f[0] = s[8];
        f[1] = h[4];
        f[3] = (x[7] == yy[7]) && (r[7] != x[7]);
      end
      3'h2: r = x & y;
      3'h3: r = x | y;
      3'h4: r = x ^ y;
      3'h5:
      begin
        r = {x[6:0], f[0]};
        f[0] = x[7];
        f[1] = x[3];
      end
      3'h6:
      begin
        r = {f[0], x[7:1]};
        f[0] = x[0];
        f[1] = x[4];
      end
      default: r = x;
    endcase
    f[4] = r[7];
    f[2] = (r == 8'h00);
    return {r, f};
  endfunction

  // ==========================================
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      conclude();
    end
  end

  // ==========================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    seed = 62;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk(`IAF_FLAG_ADDR, 8'h00);
    chkp(0, 12'h000);
    setp(0, 12'h0ff);
    wr(pa(0, `IAF_OFF_POSTINC), 8'h3c);
    chkp(0, 12'h100);
    chk(12'h0ff, 8'h3c);
    wr(12'h100, 8'h5a);
    chk(pa(0, `IAF_OFF_POSTDEC), 8'h5a);
    chkp(0, 12'h0ff);
    chk(pa(0, `IAF_OFF_PREINC), 8'h5a);
    chk(pa(0, `IAF_OFF_PLAIN), 8'h5a);
    chkp(0, 12'h100);
    // negative index, and wrap below zero to the top of the space
    wr(`IAF_WORK_ADDR, 8'hff);
    chk(pa(0, `IAF_OFF_INDEXED), 8'h3c);
    chkp(0, 12'h100);
    chk(`IAF_WORK_ADDR, 8'hff);
    setp(1, 12'h001);
    wr(12'hfff, 8'h77);
    wr(`IAF_WORK_ADDR, 8'hfe);
    chk(pa(1, `IAF_OFF_INDEXED), 8'h77);
    // step reaching zero leaves flags alone
    setp(2, 12'h001);
    wr(`IAF_FLAG_ADDR, 8'h00);
    wr(pa(2, `IAF_OFF_POSTDEC), 8'h11);
    chk(`IAF_FLAG_ADDR, 8'h00);
    chkp(2, 12'h000);
    chk(12'h001, 8'h11);
    // pointer aimed at a virtual port
    setp(1, pa(0, `IAF_OFF_PLAIN));
    chk(pa(1, `IAF_OFF_POSTINC), 8'h00);
    chk(`IAF_FLAG_ADDR, 8'h04);
    chkp(0, 12'h100);
    wr(`IAF_FLAG_ADDR, 8'h1b);
    wr(pa(1, `IAF_OFF_PLAIN), 8'hee);
    chk(`IAF_FLAG_ADDR, 8'h1b);
    chkp(0, 12'h100);
    chk(12'h100, 8'h5a);
    // lane 0 off: nothing stored, the port still steps its pointer
    core_u.lane0(1'b0);
    wr(pa(0, `IAF_OFF_POSTINC), 8'h99);
    core_u.lane0(1'b1);
    chk(12'h100, 8'h5a);
    chkp(0, 12'h101);
    // write to own low byte beats the post-decrement
    setp(0, pa(0, `IAF_OFF_LOW));
    wr(pa(0, `IAF_OFF_POSTDEC), 8'h21);
    chkp(0, 12'hf21);
    // write to own low byte beats the post-increment
    setp(2, pa(2, `IAF_OFF_LOW));
    wr(pa(2, `IAF_OFF_POSTINC), 8'h55);
    chkp(2, 12'hf55);
    for (i = 0; i < 48; i++)
    begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      f8 = 8'($random(seed));
      if (i == 0)
        a = 8'h80;
      if (i < 2)
        b = a;
      wr(`IAF_FLAG_ADDR, f8);
      chk(`IAF_FLAG_ADDR, {3'h0, f8[4:0]});
      wr(`IAF_WORK_ADDR, b);
      wr(`IAF_OPND_ADDR, a);
      wr(`IAF_CMD_ADDR, {4'h0, i[3], i[2:0]});
      ex = alu(i[2:0], a, b, f8[4:0]);
      chk(`IAF_FLAG_ADDR, {3'h0, ex[4:0]});
      chk(`IAF_WORK_ADDR, i[3] ? b : ex[12:5]);
    end
    // reset in mid-run brings pointers and flags back
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chkp(0, 12'h000);
    chkp(2, 12'h000);
    chk(`IAF_FLAG_ADDR, 8'h00);
    conclude();
  end
endmodule

`default_nettype wire
